//--- shared/fgp_pkg.sv
// constants and helpers for the five-pin general-purpose port
// assumes byte-addressed configuration space, 16-bit register words
package fgp_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int FGP_PINS = 5;
   localparam int FGP_REG_W = 16;

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0] FGP_DIR_OFF = 8'hB4;
   localparam logic [7:0] FGP_LEVEL_OFF = 8'hB6;
   localparam logic [4:0] FGP_DIR_RST = 5'h00;
   localparam logic [4:0] FGP_LEVEL_RST = 5'h00;
   localparam logic [4:0] FGP_OE_N_RST = 5'h1F;
   localparam logic [15:0] FGP_RDATA_RST = 16'h0000;
   localparam logic [10:0] FGP_UPPER_ZERO = 11'h000;

   // ****************************************
   // pin positions of the secondary functions
   // ****************************************
   localparam int FGP_PIN_CLOCK_RUN_FUNCTION = 0;
   localparam int FGP_PIN_PWROVR = 1;
   localparam int FGP_PIN_PLAIN = 2;
   localparam int FGP_PIN_SDA = 3;
   localparam int FGP_PIN_SCL = 4;

   // word match on the 16-bit register at a byte offset
   function automatic logic fgp_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
      return addr[7:1] == off[7:1];
   endfunction : fgp_hit

endpackage : fgp_pkg

//--- shared/fgp_pin_if.sv
// per-pin control and drive signals between the register core and the mux
// assumes one clock domain; the mux side is purely combinational
`timescale 1ns/1ns
interface fgp_pin_if #(parameter int W = 5);
   logic [W-1:0] dir;
   logic [W-1:0] level;
   logic [W-1:0] sec_en;
   logic [W-1:0] sec_level;
   logic [W-1:0] sec_drive;
   logic [W-1:0] out_mode;
   logic [W-1:0] drive_en;
   logic [W-1:0] drive_level;

   modport mux (input dir, level, sec_en, sec_level, sec_drive,
                output out_mode, drive_en, drive_level);
   modport core (output dir, level, sec_en, sec_level, sec_drive,
                 input out_mode, drive_en, drive_level);
endinterface : fgp_pin_if

//--- hw/fgp_pin_mux.sv
// pin ownership: general-purpose register bits or secondary function
// assumes sec_en is zero for pins that have no secondary function
`timescale 1ns/1ns
module fgp_pin_mux (
   fgp_pin_if.mux pins
);

   // ****************************************
   // ownership
   // ****************************************
   // direction ignored under secondary
   assign pins.out_mode = pins.dir & ~pins.sec_en;

   // ****************************************
   // drive
   // ****************************************
   assign pins.drive_en = pins.out_mode | (pins.sec_en & pins.sec_drive);
   assign pins.drive_level = (pins.out_mode & pins.level) |
                             (pins.sec_en & pins.sec_level);

endmodule : fgp_pin_mux

//--- hw/fgp_gpio_port.sv
// five-pin general-purpose port with direction and level registers
// assumes configuration accesses and pin levels are synchronous to clk,
// link_reset_n and global_reset_input_n are synchronous clears,
// rst_n is the power-on reset, asynchronous
`timescale 1ns/1ns
module fgp_gpio_port
   import fgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_reset_n,
   input wire logic global_reset_input_n,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [1:0] cfg_be,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic cfg_rd_valid,
   input wire logic clock_run_function_en,
   input wire logic power_override_function_en,
   input wire logic serial_bus_en,
   input wire logic [4:0] sec_level,
   input wire logic [4:0] sec_drive,
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe_n
);

   // ****************************************
   // declarations
   // ****************************************
   logic [4:0] dir_ff;
   logic [4:0] nxt_dir;
   logic [4:0] level_ff;
   logic [4:0] nxt_level;
   logic [4:0] sample_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic rd_valid_ff;
   logic [4:0] pin_out_ff;
   logic [4:0] pin_oe_n_ff;

   wire soft_clr;
   wire dir_hit;
   wire level_hit;
   wire dir_wr;
   wire level_wr;
   wire [4:0] sec_en;
   wire [4:0] out_mode;
   wire [4:0] wr_bits;
   wire [4:0] level_view;

   fgp_pin_if #(.W(FGP_PINS)) pins_if ();

   // ****************************************
   // reset sources
   // ****************************************
   // link or global reset clears
   assign soft_clr = ~link_reset_n | ~global_reset_input_n;

   // ****************************************
   // secondary function map
   // ****************************************
   // fixed pin sharing, pin 2 plain
   assign sec_en[FGP_PIN_CLOCK_RUN_FUNCTION] = clock_run_function_en;
   assign sec_en[FGP_PIN_PWROVR] = power_override_function_en;
   assign sec_en[FGP_PIN_PLAIN] = 1'b0;
   assign sec_en[FGP_PIN_SDA] = serial_bus_en;
   assign sec_en[FGP_PIN_SCL] = serial_bus_en;

   // ****************************************
   // pin mux hookup
   // ****************************************
   assign pins_if.dir = dir_ff;
   assign pins_if.level = level_ff;
   assign pins_if.sec_en = sec_en;
   assign pins_if.sec_level = sec_level;
   assign pins_if.sec_drive = sec_drive;
   assign out_mode = pins_if.out_mode;

   fgp_pin_mux u_mux (
      .pins(pins_if.mux)
   );

   // ****************************************
   // address decode
   // ****************************************
   // only lane 0 holds live bits; lane 1 writes land on read-only zeros
   assign dir_hit = fgp_hit(cfg_addr, FGP_DIR_OFF);
   assign level_hit = fgp_hit(cfg_addr, FGP_LEVEL_OFF);
   assign dir_wr = cfg_wr & cfg_be[0] & dir_hit & ~soft_clr;
   assign level_wr = cfg_wr & cfg_be[0] & level_hit & ~soft_clr;

   // ****************************************
   // direction register
   // ****************************************
   // one direction bit per pin
   assign nxt_dir = soft_clr ? FGP_DIR_RST :
                    dir_wr ? cfg_wdata[4:0] : dir_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_ff <= FGP_DIR_RST;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   // ****************************************
   // level register
   // ****************************************
   // drop bits of input or secondary pins
   assign wr_bits = (level_ff & ~out_mode) | (cfg_wdata[4:0] & out_mode);
   assign nxt_level = soft_clr ? FGP_LEVEL_RST :
                      level_wr ? wr_bits : level_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_ff <= FGP_LEVEL_RST;
      end else begin
         level_ff <= nxt_level;
      end
   end

   // ****************************************
   // input sampling
   // ****************************************
   // pins are already synchronous; one stage keeps the read path short
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_ff <= FGP_LEVEL_RST;
      end else begin
         sample_ff <= pin_in;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   // input pins show sampled level
   assign level_view = (out_mode & level_ff) | (~out_mode & sample_ff);
   // low bits follow pins after reset
   assign nxt_rdata = !cfg_rd ? rdata_ff :
                      dir_hit ? {FGP_UPPER_ZERO, dir_ff} :
                      level_hit ? {FGP_UPPER_ZERO, level_view} :
                      FGP_RDATA_RST;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= FGP_RDATA_RST;
         rd_valid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rd_valid_ff <= cfg_rd;
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   // registered so pads never see decode glitches; costs one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_ff <= FGP_LEVEL_RST;
         pin_oe_n_ff <= FGP_OE_N_RST;
      end else begin
         pin_out_ff <= pins_if.drive_level;
         pin_oe_n_ff <= ~pins_if.drive_en;
      end
   end

   assign cfg_rdata = rdata_ff;
   assign cfg_rd_valid = rd_valid_ff;
   assign pin_out = pin_out_ff;
   assign pin_oe_n = pin_oe_n_ff;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!rst_n);

   property p_clear_dir;
      soft_clr |=> (dir_ff == FGP_DIR_RST) && (level_ff == FGP_LEVEL_RST);
   endproperty
   a_clear_dir: assert property (p_clear_dir)
      else $error("direction or level not cleared by reset input");

   property p_dir_store;
      dir_wr |=> dir_ff == $past(cfg_wdata[4:0]);
   endproperty
   a_dir_store: assert property (p_dir_store)
      else $error("direction write not stored");

   property p_sec_ignores_dir;
      (sec_en[FGP_PIN_CLOCK_RUN_FUNCTION] && !sec_drive[FGP_PIN_CLOCK_RUN_FUNCTION])
         |=> pin_oe_n[FGP_PIN_CLOCK_RUN_FUNCTION];
   endproperty
   a_sec_ignores_dir: assert property (p_sec_ignores_dir)
      else $error("pin 0 driven from direction bit under secondary use");

   property p_serial_drive;
      (serial_bus_en && sec_drive[FGP_PIN_SDA])
         |=> !pin_oe_n[FGP_PIN_SDA] &&
             (pin_out[FGP_PIN_SDA] == $past(sec_level[FGP_PIN_SDA]));
   endproperty
   a_serial_drive: assert property (p_serial_drive)
      else $error("serial data pin not handed to the serial function");

   property p_plain_pin;
      dir_ff[FGP_PIN_PLAIN] ##1 dir_ff[FGP_PIN_PLAIN]
         |-> !pin_oe_n[FGP_PIN_PLAIN];
   endproperty
   a_plain_pin: assert property (p_plain_pin)
      else $error("pin 2 output not driven");

   property p_read_inputs;
      (cfg_rd && level_hit)
         |=> cfg_rd_valid &&
             ((cfg_rdata[4:0] & ~$past(out_mode)) ==
              ($past(sample_ff) & ~$past(out_mode)));
   endproperty
   a_read_inputs: assert property (p_read_inputs)
      else $error("input pin level misread");

   property p_write_outputs;
      level_wr |=> ((level_ff ^ $past(cfg_wdata[4:0])) &
                    $past(out_mode)) == 5'h00
                   ##1 ((pin_out ^ $past(level_ff)) & $past(out_mode) &
                        $past(out_mode, 2)) == 5'h00;
   endproperty
   a_write_outputs: assert property (p_write_outputs)
      else $error("output pin level not written or not driven");

   property p_write_dropped;
      level_wr |=> ((level_ff ^ $past(level_ff)) &
                    ~$past(out_mode)) == 5'h00;
   endproperty
   a_write_dropped: assert property (p_write_dropped)
      else $error("write to input or secondary pin was stored");

   property p_upper_zero;
      cfg_rd_valid |-> cfg_rdata[15:5] == FGP_UPPER_ZERO;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("reserved upper bits read nonzero");

   property p_reset_view;
      (cfg_rd && level_hit && dir_ff == FGP_DIR_RST)
         |=> cfg_rdata == {FGP_UPPER_ZERO, $past(sample_ff)};
   endproperty
   a_reset_view: assert property (p_reset_view)
      else $error("all-input level read does not mirror pins");

   property p_read_outputs;
      (cfg_rd && level_hit)
         |=> ((cfg_rdata[4:0] ^ $past(level_ff)) &
              $past(out_mode)) == 5'h00;
   endproperty
   a_read_outputs: assert property (p_read_outputs)
      else $error("output pin readback differs from driven level");

   property p_pwr_released;
      (sec_en[FGP_PIN_PWROVR] && !sec_drive[FGP_PIN_PWROVR])
         |=> pin_oe_n[FGP_PIN_PWROVR];
   endproperty
   a_pwr_released: assert property (p_pwr_released)
      else $error("pin 1 driven from direction bit under secondary use");

   property p_clock_line_drive;
      (serial_bus_en && sec_drive[FGP_PIN_SCL])
         |=> !pin_oe_n[FGP_PIN_SCL] &&
             (pin_out[FGP_PIN_SCL] == $past(sec_level[FGP_PIN_SCL]));
   endproperty
   a_clock_line_drive: assert property (p_clock_line_drive)
      else $error("serial clock pin not handed to the serial function");

   // pads release one edge after the cleared direction, not at once
   property p_clear_pads;
      soft_clr ##1 (sec_en == 5'h00) |=> pin_oe_n == FGP_OE_N_RST;
   endproperty
   a_clear_pads: assert property (p_clear_pads)
      else $error("pads still driven after reset input");

   c_dir_write: cover property (dir_wr ##1 dir_ff != FGP_DIR_RST);
   c_level_write: cover property (level_wr && out_mode != 5'h00);
   c_mixed_read: cover property (cfg_rd && level_hit &&
                                 out_mode != 5'h00 && out_mode != 5'h1F);
   c_sec_drive: cover property (serial_bus_en && sec_drive[FGP_PIN_SCL]);

endmodule : fgp_gpio_port

//--- verif/fgp_board_model.sv
// board side of the five general-purpose pins
// assumes the board holds every pin the port has released at ext_level
`timescale 1ns/1ns
module fgp_board_model (
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe_n,
   input wire logic [4:0] ext_level,
   output logic [4:0] pin_in
);
   // ****************************************
   // wire level
   // ****************************************
   // the port wins wherever it drives; the board never fights it
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : fgp_board_model

//--- verif/five_pin_gpio_port_tb_top.sv
// register-level tests of the five-pin general-purpose port
// assumes the board model closes the pad loop; inputs change at negedge
`timescale 1ns/1ns
module five_pin_gpio_port_tb_top;
   import fgp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic link_reset_n = 1'b1;
   logic global_reset_input_n = 1'b1;
   logic [7:0] cfg_addr = 8'h00;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [1:0] cfg_be = 2'h0;
   logic [15:0] cfg_wdata = 16'h0000;
   logic [15:0] cfg_rdata;
   logic cfg_rd_valid;
   logic [2:0] sec_on = 3'h0;
   logic [4:0] sec_level = 5'h00;
   logic [4:0] sec_drive = 5'h00;
   logic [4:0] ext_level = 5'h15;
   logic [4:0] pin_in;
   logic [4:0] pin_out;
   logic [4:0] pin_oe_n;
   logic [15:0] rd_word;
   int errors = 0;
   int num_checks = 0;
   logic [4:0] sec_oe_tbl [3] = '{5'h01, 5'h02, 5'h18};

   fgp_gpio_port i_fgp_gpio_port (
      .clk(clk), .rst_n(rst_n), .link_reset_n(link_reset_n),
      .global_reset_input_n(global_reset_input_n), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rd_valid(cfg_rd_valid), .clock_run_function_en(sec_on[0]),
      .power_override_function_en(sec_on[1]), .serial_bus_en(sec_on[2]),
      .sec_level(sec_level), .sec_drive(sec_drive), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n));

   fgp_board_model i_fgp_board_model (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
      .pin_in(pin_in));

   initial begin
      forever #10 clk = ~clk;
   end

   // ****************************************
   // access tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_be = 2'h1;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask : wr

   // read valid stands for one cycle only, right after the taking edge; read data holds until the next read
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clk);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      chk({15'h0000, cfg_rd_valid}, 16'h0001);
      chk(cfg_rdata, exp);
   endtask : rd

   // pads settle one edge after their causes; two edges leave margin
   task automatic pads(input logic [4:0] oe_n, input logic [4:0] lvl);
      repeat (2) @(negedge clk);
      chk({11'h000, pin_oe_n}, {11'h000, oe_n});
      chk({11'h000, pin_out}, {11'h000, lvl});
   endtask : pads

   task automatic print_verdict;
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #200000;
      errors++;
      print_verdict();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      rd(FGP_DIR_OFF, 16'h0000);
      rd(FGP_LEVEL_OFF, 16'h0015);
      pads(5'h1F, 5'h00);
      ext_level = 5'h0A;
      rd(FGP_LEVEL_OFF, 16'h000A);
      rd(8'hB7, 16'h000A);
      rd(8'hB8, 16'h0000);
      wr(FGP_DIR_OFF, 16'hFFFF);
      rd(FGP_DIR_OFF, 16'h001F);
      // upper lane alone carries no live bits, so nothing lands
      @(negedge clk);
      cfg_addr = FGP_DIR_OFF;
      cfg_be = 2'h2;
      cfg_wdata = 16'h0000;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      rd(FGP_DIR_OFF, 16'h001F);
      wr(FGP_LEVEL_OFF, 16'hFF0A);
      rd(FGP_LEVEL_OFF, 16'h000A);
      pads(5'h00, 5'h0A);
      // pins 1, 3 and 4 inputs: their write bits must be lost
      ext_level = 5'h10;
      wr(FGP_DIR_OFF, 16'h0005);
      wr(FGP_LEVEL_OFF, 16'h001F);
      rd(FGP_LEVEL_OFF, 16'h0015);
      wr(FGP_DIR_OFF, 16'h001F);
      rd(FGP_LEVEL_OFF, 16'h000F);
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         sec_on = 3'h1 << i;
         pads(sec_oe_tbl[i], 5'h0F & ~sec_oe_tbl[i]);
      end
      // all functions on; pin 2 has none, so its sec inputs do nothing
      @(negedge clk);
      ext_level = 5'h0A;
      sec_on = 3'h7;
      sec_drive = 5'h1D;
      sec_level = 5'h15;
      wr(FGP_LEVEL_OFF, 16'h0000);
      pads(5'h02, 5'h11);
      rd(FGP_LEVEL_OFF, 16'h0013);
      @(negedge clk);
      sec_on = 3'h0;
      rd(FGP_LEVEL_OFF, 16'h000B);
      for (int i = 0; i < 2; i++) begin
         wr(FGP_DIR_OFF, 16'h001F);
         wr(FGP_LEVEL_OFF, 16'h001F);
         @(negedge clk);
         link_reset_n = (i != 0);
         global_reset_input_n = (i == 0);
         @(negedge clk);
         link_reset_n = 1'b1;
         global_reset_input_n = 1'b1;
         rd(FGP_DIR_OFF, 16'h0000);
         rd(FGP_LEVEL_OFF, 16'h000A);
         pads(5'h1F, 5'h00);
      end
      print_verdict();
   end
endmodule : five_pin_gpio_port_tb_top
